// ==== esc_switch_map.vh ====
// Constants for the E1 option switch decoder: register offsets, field
// positions, reset values and timing figures.
// Assumes inclusion by bare name from the decoder source.
`ifndef ESC_SWITCH_MAP_VH
`define ESC_SWITCH_MAP_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ESC_CLK_MHZ          125
`define ESC_DEBOUNCE_US      1000
`define ESC_DEBOUNCE_CYC     (`ESC_DEBOUNCE_US * `ESC_CLK_MHZ)
`define ESC_TICK_US          1000
`define ESC_TICK_CYC         (`ESC_TICK_US * `ESC_CLK_MHZ)

// ----------------------------------------------------------------------
// APB byte offsets
// ----------------------------------------------------------------------
`define ESC_OFS_MGMT_CFG     12'h000
`define ESC_OFS_CTRL         12'h004
`define ESC_OFS_LOOP_TMO     12'h008
`define ESC_OFS_STATE        12'h00c
`define ESC_OFS_INT_STAT     12'h010
`define ESC_OFS_INT_MASK     12'h014
`define ESC_OFS_CRC_COUNT    12'h018

// ----------------------------------------------------------------------
// Option fields, same layout for second bank and management config
// (bit i is switch i+1, 1 = on)
// ----------------------------------------------------------------------
`define ESC_B_CRC            1
`define ESC_B_LOOP_TYPE      2
`define ESC_B_LOOP_RESP      3
`define ESC_B_TERM_TEST      4
`define ESC_B_PANEL          5
`define ESC_B_MGMT_SEL       6
`define ESC_B_IMPED          7

// Control register
`define ESC_B_SW_REENABLE    0

// State register fields
`define ESC_F_OPT_LSB        0
`define ESC_F_MODE_LSB       8
`define ESC_F_ADDR_LSB       16
`define ESC_B_LOOP_ACT       24
`define ESC_B_LOSS_SYNC      25
`define ESC_B_CLEAR_CHAN     26
`define ESC_B_SW_SOURCE      27

// Interrupt event bits
`define ESC_I_CRC_ERR        0
`define ESC_I_LOSS_SYNC      1
`define ESC_I_LOOP_START     2
`define ESC_I_LOOP_TMO       3

// Control source modes
`define ESC_MODE_DIP         2'h0
`define ESC_MODE_REVERT      2'h1
`define ESC_MODE_MGMT        2'h2

// Reset values
`define ESC_RST_MGMT_CFG     8'h18
`define ESC_RST_LOOP_TMO     16'h2710
`define ESC_RST_INT_MASK     4'h0

`endif

// ==== esc_switch_decoder.v ====
// Option switch decoder for an E1 access unit: debounces the switch
// banks, latches the control source at power-on and drives the settings.
// Assumes switch inputs are 1 when a switch is on and sync to clk_in;
// framer, loop pattern logic and management bus sit outside.
//
// Contract
// - Framed mode: second-bank switch two off disables, on enables CRC-4.
// - While CRC-4 is enabled, check received stream for CRC-4 errors.
// - While CRC-4 is enabled, report error counts to far end.
// - CRC-4 on but peer lacks it: declare loss of sync.
// - Panel remote loop: V.54 if type switch off, line loop if on.
// - Response switch off answers loop commands; on neither sends nor answers.
// - In-band remote loopback ends when loopback timeout expires.
// - Terminal loop request honoured when test switch off, ignored when on.
// - Front-panel toggles accepted when panel switch off, ignored when on.
// - Management select off gives network management, on gives terminal menu.
// - Switch configuration re-enabled by management or by hardware reset.
// - Impedance switch on selects 75 ohm, off selects 120 ohm.
// - Third bank picks control source; all off means switch control.
// - All third-bank switches on at power-up reverts to switch control.
// - Other third-bank patterns: management control, pattern is card address.
// - Address: switch one LSB, eight MSB; on reads 0, off reads 1.
// - Unframed 2.048 Mbps rate ignores the CRC-4 switch.
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "esc_switch_map.vh"

module esc_switch_decoder #(
    parameter DEBOUNCE_CYC = `ESC_DEBOUNCE_CYC,
    parameter TICK_CYC     = `ESC_TICK_CYC
) (
    input  wire        clk_in,
    input  wire        rst_in,
    // APB slave
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [11:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    // Switch banks, 1 = on
    input  wire [4:0]  rate_switch_in,
    input  wire [7:0]  option_switch_in,
    input  wire [7:0]  control_address_switch_bank_in,
    // Events from the rest of the unit
    input  wire        crc_error_in,
    input  wire        peer_multiframe_in,
    input  wire        panel_remote_loop_in,
    input  wire [3:0]  panel_toggle_in,
    input  wire        inband_loop_cmd_in,
    input  wire        terminal_loop_req_in,
    // Settings
    output reg         crc_multiframe_out,
    output reg         crc_report_out,
    output reg         loss_of_sync_out,
    output reg         start_remote_digital_loop_out,
    output reg         start_line_side_loop_out,
    output reg         loop_active_out,
    output reg         terminal_loop_out,
    output reg  [3:0]  panel_toggle_out,
    output reg         terminal_menu_control_out,
    output reg         lbo_75_out,
    output reg  [1:0]  control_mode_out,
    output reg  [7:0]  card_address_out,
    output reg         irq_out
);

    // ------------------------------------------------------------------
    // Synchronise and debounce
    // ------------------------------------------------------------------
    localparam SW_W = 21;
    reg  [SW_W-1:0] sync1_r;
    reg  [SW_W-1:0] sync2_r;
    reg  [SW_W-1:0] sync3_r;
    reg  [SW_W-1:0] deb_r;
    reg  [31:0]     deb_cnt_r;
    reg             settled_r;
    wire [SW_W-1:0] raw_sw = {rate_switch_in, option_switch_in,
                              control_address_switch_bank_in};
    wire [7:0]      bank3  = deb_r[7:0];
    wire [7:0]      bank2  = deb_r[15:8];
    wire [4:0]      bank1  = deb_r[20:16];

    genvar gi;
    generate
        for (gi = 0; gi < SW_W; gi = gi + 1) begin : g_sync
            always @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                    sync3_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= raw_sw[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                end
            end
        end
    endgenerate

    // A bank change restarts the stable-time count; bouncing never lands
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            deb_cnt_r <= 32'h0;
            deb_r     <= {SW_W{1'b0}};
            settled_r <= 1'b0;
        end else if (sync2_r != sync3_r) begin
            deb_cnt_r <= 32'h0;
        end else if (deb_cnt_r >= DEBOUNCE_CYC - 1) begin
            deb_r     <= sync3_r;
            settled_r <= 1'b1;
        end else begin
            deb_cnt_r <= deb_cnt_r + 32'h1;
        end
    end

    // ------------------------------------------------------------------
    // Control source, latched once after reset
    // ------------------------------------------------------------------
    reg       latched_r;
    reg [1:0] mode_r;
    reg [7:0] addr_r;

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            latched_r <= 1'b0;
            mode_r    <= `ESC_MODE_DIP;
            addr_r    <= 8'h00;
        end else if (settled_r && !latched_r) begin
            latched_r <= 1'b1;
            if (bank3 == 8'h00) begin
                mode_r <= `ESC_MODE_DIP;
            end else if (bank3 == 8'hff) begin
                mode_r <= `ESC_MODE_REVERT;
            end else begin
                mode_r <= `ESC_MODE_MGMT;
                addr_r <= ~bank3;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register file state
    // ------------------------------------------------------------------
    reg [7:0]  mgmt_cfg_r;
    reg        sw_reenable_r;
    reg [15:0] loop_tmo_r;
    reg [3:0]  int_stat_r;
    reg [3:0]  int_mask_r;
    reg [15:0] crc_count_r;

    // switch configuration from management or hardware reset
    wire sw_source = (mode_r != `ESC_MODE_MGMT) || sw_reenable_r;
    wire [7:0] opt = sw_source ? bank2 : mgmt_cfg_r;

    // clear channel rate is all rate switches off
    wire clear_chan = (bank1 == 5'h00);
    wire crc_en     = opt[`ESC_B_CRC] && !clear_chan;
    wire loop_ok    = !opt[`ESC_B_LOOP_RESP];
    wire panel_ok   = !opt[`ESC_B_PANEL];

    // ------------------------------------------------------------------
    // Remote loop and timeout
    // ------------------------------------------------------------------
    reg [31:0] tick_cnt_r;
    reg [15:0] loop_cnt_r;
    reg        panel_loop_d_r;
    reg        loop_start_ev;
    reg        loop_tmo_ev;
    wire       tick = (tick_cnt_r >= TICK_CYC - 1);
    wire       panel_rise = panel_remote_loop_in && !panel_loop_d_r;
    wire       req_panel = panel_rise && panel_ok && loop_ok;
    wire       req_inband = inband_loop_cmd_in && loop_ok;

    // Idle outside a loop, so every loop gets whole ticks
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tick_cnt_r <= 32'h0;
        end else if (tick || !loop_active_out) begin
            tick_cnt_r <= 32'h0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            panel_loop_d_r                <= 1'b0;
            start_remote_digital_loop_out <= 1'b0;
            start_line_side_loop_out      <= 1'b0;
            loop_active_out               <= 1'b0;
            loop_cnt_r                    <= 16'h0;
            loop_start_ev                 <= 1'b0;
            loop_tmo_ev                   <= 1'b0;
        end else begin
            panel_loop_d_r                <= panel_remote_loop_in;
            start_remote_digital_loop_out <= 1'b0;
            start_line_side_loop_out      <= 1'b0;
            loop_start_ev                 <= 1'b0;
            loop_tmo_ev                   <= 1'b0;
            if (!loop_active_out && (req_panel || req_inband)) begin
                loop_active_out <= 1'b1;
                loop_cnt_r      <= 16'h0;
                loop_start_ev   <= 1'b1;
                if (req_panel && !opt[`ESC_B_LOOP_TYPE]) begin
                    start_remote_digital_loop_out <= 1'b1;
                end else if (req_panel) begin
                    start_line_side_loop_out <= 1'b1;
                end
            end else if (loop_active_out && !loop_ok) begin
                loop_active_out <= 1'b0;
            end else if (loop_active_out && tick) begin
                if (loop_cnt_r + 16'h1 >= loop_tmo_r) begin
                    loop_active_out <= 1'b0;
                    loop_tmo_ev     <= 1'b1;
                end else begin
                    loop_cnt_r <= loop_cnt_r + 16'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Settings outputs
    // ------------------------------------------------------------------
    reg lsync_d_r;
    wire lsync = crc_en && !peer_multiframe_in;

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            crc_multiframe_out        <= 1'b0;
            crc_report_out            <= 1'b0;
            loss_of_sync_out          <= 1'b0;
            lsync_d_r                 <= 1'b0;
            terminal_loop_out         <= 1'b0;
            panel_toggle_out          <= 4'h0;
            terminal_menu_control_out <= 1'b0;
            lbo_75_out                <= 1'b0;
            control_mode_out          <= `ESC_MODE_DIP;
            card_address_out          <= 8'h00;
            crc_count_r               <= 16'h0;
        end else begin
            crc_multiframe_out <= crc_en;
            crc_report_out     <= crc_en;
            loss_of_sync_out   <= lsync;
            lsync_d_r          <= lsync;
            terminal_loop_out  <= terminal_loop_req_in &&
                                  !opt[`ESC_B_TERM_TEST];
            panel_toggle_out   <= panel_ok ? panel_toggle_in : 4'h0;
            terminal_menu_control_out <= opt[`ESC_B_MGMT_SEL];
            lbo_75_out         <= opt[`ESC_B_IMPED];
            control_mode_out   <= mode_r;
            card_address_out   <= addr_r;
            // Saturates so software never reads a wrapped count
            // errors counted only while enabled
            if (crc_en && crc_error_in && crc_count_r != 16'hffff) begin
                crc_count_r <= crc_count_r + 16'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // APB slave, one wait state
    // ------------------------------------------------------------------
    wire acc  = psel_in && penable_in && pready_out;
    wire wr   = acc && pwrite_in;
    wire rd_is = acc && !pwrite_in &&
                 (paddr_in == `ESC_OFS_INT_STAT);
    reg  [31:0] rd_val;
    reg         hit;
    wire [3:0]  events = {loop_tmo_ev, loop_start_ev,
                          lsync && !lsync_d_r,
                          crc_en && crc_error_in};

    always @* begin
        rd_val = 32'h0;
        hit    = 1'b1;
        case (paddr_in)
            `ESC_OFS_MGMT_CFG:  rd_val[7:0] = mgmt_cfg_r;
            `ESC_OFS_CTRL:      rd_val[`ESC_B_SW_REENABLE] = sw_reenable_r;
            `ESC_OFS_LOOP_TMO:  rd_val[15:0] = loop_tmo_r;
            `ESC_OFS_STATE: begin
                rd_val[`ESC_F_OPT_LSB +: 8]  = opt;
                rd_val[`ESC_F_MODE_LSB +: 2] = mode_r;
                rd_val[`ESC_F_ADDR_LSB +: 8] = addr_r;
                rd_val[`ESC_B_LOOP_ACT]      = loop_active_out;
                rd_val[`ESC_B_LOSS_SYNC]     = loss_of_sync_out;
                rd_val[`ESC_B_CLEAR_CHAN]    = clear_chan;
                rd_val[`ESC_B_SW_SOURCE]     = sw_source;
            end
            `ESC_OFS_INT_STAT:  rd_val[3:0] = int_stat_r;
            `ESC_OFS_INT_MASK:  rd_val[3:0] = int_mask_r;
            `ESC_OFS_CRC_COUNT: rd_val[15:0] = crc_count_r;
            default:            hit = 1'b0;
        endcase
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pready_out    <= 1'b0;
            pslverr_out   <= 1'b0;
            prdata_out    <= 32'h0;
            mgmt_cfg_r    <= `ESC_RST_MGMT_CFG;
            sw_reenable_r <= 1'b0;
            loop_tmo_r    <= `ESC_RST_LOOP_TMO;
            int_mask_r    <= `ESC_RST_INT_MASK;
        end else begin
            // Read data is taken in the first access cycle, ready one later; write data lands in the ready cycle
            pready_out  <= psel_in && penable_in && !pready_out;
            pslverr_out <= psel_in && penable_in && !pready_out && !hit;
            if (psel_in && penable_in && !pready_out) begin
                prdata_out <= pwrite_in ? 32'h0 : rd_val;
            end
            if (wr && paddr_in == `ESC_OFS_MGMT_CFG) begin
                mgmt_cfg_r <= pwdata_in[7:0];
            end
            if (wr && paddr_in == `ESC_OFS_CTRL) begin
                sw_reenable_r <= pwdata_in[`ESC_B_SW_REENABLE];
            end
            if (wr && paddr_in == `ESC_OFS_LOOP_TMO) begin
                loop_tmo_r <= pwdata_in[15:0];
            end
            if (wr && paddr_in == `ESC_OFS_INT_MASK) begin
                int_mask_r <= pwdata_in[3:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupts: read clears, a new event in the same cycle survives
    // ------------------------------------------------------------------
    // Clear only bits the read returned; later events stay pending
    wire [3:0] int_stat_nxt = (int_stat_r &
        ~(rd_is ? prdata_out[3:0] : 4'h0)) | events;

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            int_stat_r <= 4'h0;
            irq_out    <= 1'b0;
        end else begin
            int_stat_r <= int_stat_nxt;
            irq_out    <= |(int_stat_nxt & int_mask_r);
        end
    end

endmodule // esc_switch_decoder

`default_nettype wire

// ==== esc_sw_banks.sv ====
// Operator model of the three option switch banks, with contact bounce.
// Assumes the bench changes the wanted settings just after a clock edge.
`timescale 1ns/1ps
`default_nettype none

module esc_sw_banks (
    input  wire logic       clk_in,
    input  wire logic [4:0] rate_in,
    input  wire logic [7:0] opt_in,
    input  wire logic [7:0] bank3_in,
    output wire logic [4:0] rate_out,
    output wire logic [7:0] opt_out,
    output wire logic [7:0] bank3_out
);
    logic [20:0] last_r = 21'h0;
    logic [20:0] out_r  = 21'h0;
    logic [1:0]  bnc_r  = 2'h0;

    // Contacts chatter for three cycles after any change, so a decoder
    // without a debounce sees wrong settings first
    always @(posedge clk_in) begin
        if ({rate_in, opt_in, bank3_in} != last_r) begin
            last_r <= {rate_in, opt_in, bank3_in};
            bnc_r  <= 2'h3;
        end else if (bnc_r != 2'h0) begin
            bnc_r <= bnc_r - 2'h1;
        end
        out_r <= (bnc_r != 2'h0) ? last_r ^ {21{bnc_r[0]}} : last_r;
    end

    assign {rate_out, opt_out, bank3_out} = out_r;
endmodule // esc_sw_banks

`default_nettype wire

// ==== esc_switch_sva.sv ====
// Port-level checker for the option switch decoder.
// Assumes one clock domain and the active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

module esc_switch_sva (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        crc_multiframe_out,
    input wire logic        crc_report_out,
    input wire logic        loss_of_sync_out,
    input wire logic        start_remote_digital_loop_out,
    input wire logic        start_line_side_loop_out,
    input wire logic        loop_active_out,
    input wire logic [1:0]  control_mode_out,
    input wire logic [7:0]  card_address_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    chk_ready_wait: assert property ($rose(psel_in && penable_in)
        |-> !pready_out ##1 pready_out) else $error("late ready");
    chk_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready held");
    chk_err_data: assert property (pslverr_out |-> pready_out
        && prdata_out == 32'h0) else $error("bad error response");
    chk_report_crc: assert property (
        crc_report_out == crc_multiframe_out) else $error("report off");
    chk_sync_crc: assert property (
        loss_of_sync_out |-> crc_multiframe_out) else $error("stray sync");
    chk_start_loop: assert property (
        (start_remote_digital_loop_out || start_line_side_loop_out)
        |-> loop_active_out && !$past(loop_active_out))
        else $error("start outside loop entry");
    chk_start_pulse: assert property (
        (start_remote_digital_loop_out || start_line_side_loop_out)
        |=> !(start_remote_digital_loop_out || start_line_side_loop_out))
        else $error("start pulse too long");
    chk_mode_held: assert property (
        control_mode_out != 2'h0 |=> $stable(control_mode_out)
        && $stable(card_address_out)) else $error("mode changed");
    chk_mode_legal: assert property (
        control_mode_out != 2'h3) else $error("illegal mode");
    chk_addr_mgmt: assert property (
        card_address_out != 8'h00 |-> control_mode_out == 2'h2
        && card_address_out != 8'hff) else $error("address outside mgmt");
    chk_revert_addr: assert property (
        control_mode_out == 2'h1 |-> card_address_out == 8'h00)
        else $error("revert with address");

    cover property (start_remote_digital_loop_out);
    cover property (start_line_side_loop_out);
    cover property (control_mode_out == 2'h2);
    cover property (pslverr_out);
endmodule // esc_switch_sva

bind esc_switch_decoder esc_switch_sva u_sva (.clk_in, .rst_in, .psel_in,
    .penable_in, .prdata_out, .pready_out, .pslverr_out, .crc_multiframe_out,
    .crc_report_out, .loss_of_sync_out, .start_remote_digital_loop_out,
    .start_line_side_loop_out, .loop_active_out, .control_mode_out,
    .card_address_out);

`default_nettype wire

// ==== esc_switch_decoder_tb.sv ====
// Self-checking bench for the option switch decoder.
// Assumes the switch bank model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, e); end end

module esc_switch_decoder_tb;
    logic        clk_in = 1'b0, rst_in = 1'b1, clr_saw = 1'b0, src_sw = 1'b0;
    logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h0;
    logic [31:0] pwdata_in = 32'h0, prdata_out, r;
    logic        crc_error_in = 1'b0, peer_multiframe_in = 1'b0;
    logic        panel_remote_loop_in = 1'b0, inband_loop_cmd_in = 1'b0;
    logic        terminal_loop_req_in = 1'b0;
    logic [3:0]  panel_toggle_in = 4'h0, panel_toggle_out;
    logic [4:0]  rate = 5'h1f, rate_switch_in;
    logic [7:0]  opt = 8'h00, bank3 = 8'h00, cfg = 8'h18, addr_e = 8'h00;
    logic [7:0]  option_switch_in, control_address_switch_bank_in;
    logic [7:0]  card_address_out;
    logic [1:0]  control_mode_out, mode_e = 2'h0, saw_r = 2'h0;
    logic        pready_out, pslverr_out, crc_multiframe_out, crc_report_out;
    logic        loss_of_sync_out, start_remote_digital_loop_out, irq_out;
    logic        start_line_side_loop_out, loop_active_out, lbo_75_out;
    logic        terminal_loop_out, terminal_menu_control_out;
    logic [32:0] exp_rd[$], e33;
    logic [23:0] exp_pt[$], e24;
    int          failures = 0, compares = 0, seed = 32'hf729c3fb;
    event        ev_pt;
    wire  [23:0] snap = {control_mode_out, card_address_out,
        crc_multiframe_out, crc_report_out, loss_of_sync_out,
        terminal_loop_out, panel_toggle_out, terminal_menu_control_out,
        lbo_75_out, saw_r, loop_active_out, irq_out};

    always #4 clk_in = ~clk_in;

    esc_sw_banks u_banks (.clk_in, .rate_in(rate), .opt_in(opt),
        .bank3_in(bank3), .rate_out(rate_switch_in),
        .opt_out(option_switch_in), .bank3_out(control_address_switch_bank_in));

    esc_switch_decoder #(.DEBOUNCE_CYC(4), .TICK_CYC(8)) DUT (.clk_in,
        .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .prdata_out, .pready_out, .pslverr_out, .rate_switch_in,
        .option_switch_in, .control_address_switch_bank_in, .crc_error_in,
        .peer_multiframe_in, .panel_remote_loop_in, .panel_toggle_in,
        .inband_loop_cmd_in, .terminal_loop_req_in, .crc_multiframe_out,
        .crc_report_out, .loss_of_sync_out, .start_remote_digital_loop_out,
        .start_line_side_loop_out, .loop_active_out, .terminal_loop_out,
        .panel_toggle_out, .terminal_menu_control_out, .lbo_75_out,
        .control_mode_out, .card_address_out, .irq_out);

    // ------------------------------------------------------------------
    // Monitor: start pulses are only one cycle, so they are kept sticky
    // ------------------------------------------------------------------
    always @(posedge clk_in) begin
        saw_r <= clr_saw ? 2'h0 : saw_r | {start_remote_digital_loop_out,
            start_line_side_loop_out};
        if (psel_in && penable_in && pready_out && !pwrite_in
            && exp_rd.size() > 0) begin
            e33 = exp_rd.pop_front();
            `CHK({pslverr_out, prdata_out}, e33)
        end
    end

    always @(ev_pt) begin
        e24 = exp_pt.pop_front();
        `CHK(snap, e24)
    end

    function automatic logic [23:0] expect_of(input logic [3:0] tail);
        logic [7:0] eff;
        logic       crc;
        eff = (mode_e == 2'h2 && !src_sw) ? cfg : opt;
        crc = eff[1] && rate != 5'h0;
        return {mode_e, addr_e, crc, crc, crc && !peer_multiframe_in,
            !eff[4] && terminal_loop_req_in,
            eff[5] ? 4'h0 : panel_toggle_in, eff[6], eff[7], tail};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_rd.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic chk_pt(input logic [3:0] tail);
        @(negedge clk_in);
        exp_pt.push_back(expect_of(tail));
        -> ev_pt;
        @(posedge clk_in);
    endtask

    task automatic power_up(input logic [7:0] b3);
        bank3 <= b3;
        rst_in <= 1'b1;
        clr_saw <= 1'b1;
        tick(10);
        rst_in <= 1'b0;
        clr_saw <= 1'b0;
        tick(30);
    endtask

    task automatic wait_act(input logic want);
        int n = 0;
        while (loop_active_out !== want && n < 100) begin
            @(posedge clk_in);
            n++;
        end
        if (loop_active_out !== want) failures++;
    endtask

    task automatic end_sim;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        #(8 * 20000);
        failures++;
        end_sim;
    end

    initial begin
        power_up(8'h00);
        rd(12'h000, {1'b0, 32'h18});
        rd(12'h008, {1'b0, 32'h2710});
        rd(12'h014, 33'h0);
        rd(12'h100, {1'b1, 32'h0});
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            opt <= r[7:0];
            rate <= (i % 3 == 0) ? 5'h00 : r[12:8];
            peer_multiframe_in <= r[13];
            panel_toggle_in <= r[17:14];
            terminal_loop_req_in <= r[18];
            tick(30);
            chk_pt(4'h0);
        end
        opt <= 8'h02;
        rate <= 5'h1f;
        tick(30);
        repeat (3) begin
            crc_error_in <= 1'b1;
            tick(1);
            crc_error_in <= 1'b0;
            tick(2);
        end
        rate <= 5'h00;
        tick(30);
        crc_error_in <= 1'b1;
        tick(1);
        crc_error_in <= 1'b0;
        tick(3);
        rd(12'h018, {1'b0, 32'h3});
        rate <= 5'h1f;
        apb(1'b1, 12'h008, 32'h2);
        apb(1'b1, 12'h014, 32'hc);
        for (int t = 0; t < 3; t++) begin
            opt <= (t == 2) ? 8'h08 : {5'h0, t[0], 2'h0};
            tick(30);
            apb(1'b0, 12'h010, 32'h0);
            clr_saw <= 1'b1;
            tick(1);
            clr_saw <= 1'b0;
            panel_remote_loop_in <= 1'b1;
            inband_loop_cmd_in <= (t == 2);
            if (t < 2) wait_act(1'b1);
            else tick(20);
            tick(3);
            chk_pt(t == 2 ? 4'h0 : {t == 0, t == 1, 2'b11});
            wait_act(1'b0);
            panel_remote_loop_in <= 1'b0;
            inband_loop_cmd_in <= 1'b0;
            tick(3);
            rd(12'h010, {1'b0, t == 2 ? 32'h0 : 32'hc});
        end
        mode_e = 2'h1;
        power_up(8'hff);
        chk_pt(4'h0);
        bank3 <= 8'h4a;
        tick(30);
        chk_pt(4'h0);
        mode_e = 2'h2;
        addr_e = 8'hb5;
        power_up(8'h4a);
        chk_pt(4'h0);
        opt <= 8'h3d;
        cfg = 8'hc2;
        apb(1'b1, 12'h000, 32'hc2);
        tick(30);
        chk_pt(4'h0);
        apb(1'b1, 12'h004, 32'h1);
        src_sw = 1'b1;
        tick(30);
        chk_pt(4'h0);
        rd(12'h004, {1'b0, 32'h1});
        end_sim;
    end
endmodule // esc_switch_decoder_tb

`default_nettype wire
